// ===== rtl/bst_regs.svh
// Register map, field positions and self-test constants for the backoff self-test block
`ifndef BST_REGS_SVH
`define BST_REGS_SVH
`define BST_OFF_CMD 8'h00
`define BST_OFF_LINK 8'h04
`define BST_OFF_BASE 8'h08
`define BST_OFF_CTRL 8'h0C
`define BST_OFF_CFG 8'h10
`define BST_OFF_STAT 8'h14
`define BST_OFF_NEXT 8'h18
`define BST_BIT_LAST 31
`define BST_BIT_SUSP 30
`define BST_BIT_INT 29
`define BST_BIT_C 15
`define BST_BIT_OK 13
`define BST_BIT_F 11
`define BST_CMD_DIAG 3'h7
`define BST_CTRL_GO 0
`define BST_CTRL_NA_SUSP 1
`define BST_CFG_RESET 16'h0000
`define BST_P2_CFG 16'h0363
`define BST_P2_COLS 4'hD
`define BST_SLOT_END 11'h400
`endif

// ===== rtl/bst_pkg.sv
// Types for the backoff self-test block
package bst_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_DECODE = 4'b0001,
    ST_P1_RST = 4'b0010,
    ST_P1_RUN = 4'b0011,
    ST_P1_CHK = 4'b0100,
    ST_P2_RST = 4'b0101,
    ST_P2_RUN = 4'b0110,
    ST_P2_CHK = 4'b0111,
    ST_STATUS = 4'b1000,
    ST_DONE = 4'b1001
  } bst_state_t;
  typedef enum logic [1:0] {
    UNIT_IDLE = 2'b00,
    UNIT_ACTIVE = 2'b01,
    UNIT_SUSP = 2'b10
  } bst_unit_t;
endpackage

// ===== rtl/bst_top.sv
// Backoff self-test command engine with AHB-Lite register slave
//
// The register offsets and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "bst_regs.svh"
module bst_top (
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic o_exec_irq,
  output logic o_not_active_irq,
  output logic o_busy,
  output logic [31:0] o_next_addr,
  output logic [15:0] o_bof_cfg,
  output var bst_pkg::bst_unit_t o_unit_state
);
  import bst_pkg::*;

  function automatic logic all_ones10(input logic [9:0] v);
    all_ones10 = &v;
  endfunction

  bst_state_t st_q;
  logic [31:0] cmd_q;
  logic [31:0] link_q;
  logic [31:0] base_q;
  logic na_on_susp_q;
  logic [15:0] cfg_q;
  logic [29:0] lfsr_q;
  logic [9:0] bo_cnt_q;
  logic [10:0] slot_cnt_q;
  logic [3:0] col_cnt_q;
  logic [9:0] bo_sr_q;
  logic p1_fail_q;
  logic p2_fail_q;
  logic bad_cmd_q;
  logic [7:0] a_addr_q;
  logic a_wr_q;
  logic a_rd_q;
  logic wr_cmd;
  logic go;
  logic set_c;
  logic [31:0] rdata;
  logic [9:0] wait_len;
  logic [9:0] mask_val;

  // Bus: writes complete with no wait; reads take one wait so hrdata comes from a flop
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      a_addr_q <= 8'h00;
      a_wr_q <= 1'b0;
      a_rd_q <= 1'b0;
    end else begin
      a_wr_q <= 1'b0;
      a_rd_q <= 1'b0;
      if (i_hsel && i_htrans[1] && i_hready) begin
        a_addr_q <= i_haddr[7:0];
        a_wr_q <= i_hwrite;
        a_rd_q <= !i_hwrite;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_hreadyout <= 1'b1;
      o_hrdata <= 32'h0000_0000;
      o_hresp <= 1'b0;
    end else begin
      o_hresp <= 1'b0;
      if (i_hsel && i_htrans[1] && i_hready && !i_hwrite) begin
        o_hreadyout <= 1'b0;
      end else if (a_rd_q) begin
        o_hreadyout <= 1'b1;
        o_hrdata <= rdata;
      end
    end
  end

  always_comb begin
    rdata = 32'h0000_0000;
    case (a_addr_q)
      `BST_OFF_CMD: rdata = cmd_q;
      `BST_OFF_LINK: rdata = link_q;
      `BST_OFF_BASE: rdata = base_q;
      `BST_OFF_CTRL: rdata = {30'h0000_0000, na_on_susp_q, 1'b0};
      `BST_OFF_CFG: rdata = {16'h0000, cfg_q};
      `BST_OFF_STAT: rdata = {24'h0000_00, bad_cmd_q, p2_fail_q, p1_fail_q, st_q, 1'b0};
      `BST_OFF_NEXT: rdata = o_next_addr;
      default: rdata = 32'h0000_0000;
    endcase
  end

  assign wr_cmd = a_wr_q && (a_addr_q == `BST_OFF_CMD);
  // A start request while the engine runs is dropped
  assign go = a_wr_q && (a_addr_q == `BST_OFF_CTRL) && i_hwdata[`BST_CTRL_GO]
              && (st_q == ST_IDLE);
  assign set_c = (st_q == ST_STATUS);

  // Command word: software loads it; the status byte is written back by hardware
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cmd_q <= 32'h0000_0000;
    end else if (set_c) begin
      cmd_q[`BST_BIT_C] <= 1'b1;
      cmd_q[`BST_BIT_OK] <= !(p1_fail_q || p2_fail_q || bad_cmd_q);
      // Phase results from an earlier run must not leak into an unknown command
      cmd_q[`BST_BIT_F] <= (p1_fail_q || p2_fail_q) && !bad_cmd_q;
      if (wr_cmd) begin
        cmd_q[31:16] <= i_hwdata[31:16];
      end
    end else if (wr_cmd) begin
      cmd_q <= i_hwdata;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      link_q <= 32'h0000_0000;
      base_q <= 32'h0000_0000;
      na_on_susp_q <= 1'b0;
      cfg_q <= `BST_CFG_RESET;
    end else if (a_wr_q) begin
      case (a_addr_q)
        `BST_OFF_LINK: link_q <= i_hwdata;
        `BST_OFF_BASE: base_q <= i_hwdata;
        `BST_OFF_CTRL: na_on_susp_q <= i_hwdata[`BST_CTRL_NA_SUSP];
        `BST_OFF_CFG: cfg_q <= i_hwdata[15:0];
        default: ;
      endcase
    end
  end

  // Sequencer
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_q <= ST_IDLE;
    end else begin
      unique case (st_q)
        ST_IDLE: if (go) st_q <= ST_DECODE;
        ST_DECODE: begin
          if (cmd_q[18:16] == `BST_CMD_DIAG) begin
            st_q <= ST_P1_RST;
          end else begin
            st_q <= ST_STATUS;
          end
        end
        ST_P1_RST: st_q <= ST_P1_RUN;
        ST_P1_RUN: if (all_ones10(bo_cnt_q)) st_q <= ST_P1_CHK;
        ST_P1_CHK: st_q <= ST_P2_RST;
        ST_P2_RST: st_q <= ST_P2_RUN;
        ST_P2_RUN: if (bo_sr_q[9] || (&col_cnt_q)) st_q <= ST_P2_CHK;
        ST_P2_CHK: st_q <= ST_STATUS;
        ST_STATUS: st_q <= ST_DONE;
        ST_DONE: st_q <= ST_IDLE;
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      bad_cmd_q <= 1'b0;
    end else if (st_q == ST_DECODE) begin
      bad_cmd_q <= (cmd_q[18:16] != `BST_CMD_DIAG);
    end
  end

  // Phase two backoff wait: slot time plus linear priority; the masked random slots only feed the fault check
  assign mask_val = lfsr_q[9:0] & bo_sr_q;
  assign wait_len = {6'h00, o_bof_cfg[3:0]} + {6'h00, o_bof_cfg[7:4]};

  // Backoff counters under test
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      lfsr_q <= 30'h0000_0000;
      bo_cnt_q <= 10'h000;
      slot_cnt_q <= 11'h000;
      col_cnt_q <= 4'h0;
      bo_sr_q <= 10'h000;
    end else begin
      unique case (st_q)
        ST_P1_RST, ST_P2_RST: begin
          lfsr_q <= 30'h0000_0000;
          bo_cnt_q <= 10'h000;
          slot_cnt_q <= 11'h000;
          col_cnt_q <= 4'h0;
          bo_sr_q <= 10'h000;
        end
        ST_P1_RUN: begin
          // All stages step together so the wrap points line up
          lfsr_q <= {lfsr_q[28:0], ~(lfsr_q[29] ^ lfsr_q[5] ^ lfsr_q[3] ^ lfsr_q[0])};
          bo_cnt_q <= bo_cnt_q + 10'h001;
          slot_cnt_q <= slot_cnt_q + 11'h001;
          col_cnt_q <= col_cnt_q + 4'h1;
          bo_sr_q <= {bo_sr_q[8:0], 1'b1};
        end
        ST_P2_RUN: begin
          lfsr_q <= {lfsr_q[28:0], ~(lfsr_q[29] ^ lfsr_q[5] ^ lfsr_q[3] ^ lfsr_q[0])};
          slot_cnt_q <= slot_cnt_q + 11'h001;
          if (bo_cnt_q >= wait_len) begin
            // Emulated collision ends each transmit attempt
            bo_cnt_q <= 10'h000;
            col_cnt_q <= col_cnt_q + 4'h1;
            if (col_cnt_q >= o_bof_cfg[11:8]) begin
              bo_sr_q <= {bo_sr_q[8:0], 1'b1};
            end
          end else begin
            bo_cnt_q <= bo_cnt_q + 10'h001;
          end
        end
        default: ;
      endcase
    end
  end

  // Phase results
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      p1_fail_q <= 1'b0;
    end else if (st_q == ST_P1_RST) begin
      p1_fail_q <= 1'b0;
    end else if (st_q == ST_P1_RUN) begin
      if (all_ones10(lfsr_q[9:0]) && !all_ones10(bo_sr_q)) begin
        p1_fail_q <= 1'b1;
      end
    end else if (st_q == ST_P1_CHK) begin
      if ((bo_cnt_q != 10'h000) || (slot_cnt_q != `BST_SLOT_END)
          || (col_cnt_q != 4'h0)) begin
        p1_fail_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      p2_fail_q <= 1'b0;
    end else if (st_q == ST_P2_RST) begin
      p2_fail_q <= 1'b0;
    end else if (st_q == ST_P2_RUN) begin
      if ((mask_val & ~bo_sr_q) != 10'h000) begin
        p2_fail_q <= 1'b1;
      end
    end else if (st_q == ST_P2_CHK) begin
      if (!bo_sr_q[9] || (col_cnt_q != `BST_P2_COLS)) begin
        p2_fail_q <= 1'b1;
      end
    end
  end

  // Applied backoff setup: test values only while phase two runs
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_bof_cfg <= `BST_CFG_RESET;
    end else if ((st_q == ST_P2_RST) || (st_q == ST_P2_RUN)) begin
      o_bof_cfg <= `BST_P2_CFG;
    end else begin
      o_bof_cfg <= cfg_q;
    end
  end

  // Completion: unit state, interrupts, next block pointer
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_unit_state <= UNIT_IDLE;
      o_exec_irq <= 1'b0;
      o_not_active_irq <= 1'b0;
      o_next_addr <= 32'h0000_0000;
      o_busy <= 1'b0;
    end else begin
      o_exec_irq <= 1'b0;
      o_not_active_irq <= 1'b0;
      o_busy <= (st_q != ST_IDLE) && (st_q != ST_DONE) || go;
      if (go) begin
        o_unit_state <= UNIT_ACTIVE;
      end else if (st_q == ST_DONE) begin
        o_exec_irq <= cmd_q[`BST_BIT_INT];
        o_next_addr <= base_q + link_q;
        if (cmd_q[`BST_BIT_LAST]) begin
          o_unit_state <= UNIT_IDLE;
          o_not_active_irq <= 1'b1;
        end else if (cmd_q[`BST_BIT_SUSP]) begin
          o_unit_state <= UNIT_SUSP;
          o_not_active_irq <= na_on_susp_q;
        end
      end
    end
  end

  sequence s_done;
    st_q == ST_DONE;
  endsequence

  sequence s_p1_wrap;
    (st_q == ST_P1_RUN) && all_ones10(bo_cnt_q);
  endsequence

  decode_diag_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    (st_q == ST_DECODE) && (cmd_q[18:16] == 3'h7) |=> (st_q == ST_P1_RST) ##1 (st_q == ST_P1_RUN))
    else $error("diagnose code did not start phase one");
  el_idle_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    s_done and cmd_q[31] |=> (o_unit_state == UNIT_IDLE) && o_not_active_irq)
    else $error("end of list did not idle the unit with interrupt");
  susp_irq_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    s_done and !cmd_q[31] && cmd_q[30] |=> (o_unit_state == UNIT_SUSP)
    && (o_not_active_irq == $past(na_on_susp_q)))
    else $error("suspend handling wrong");
  exec_irq_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    o_exec_irq |-> $past(st_q == ST_DONE) && $past(cmd_q[29]))
    else $error("command executed interrupt without cause");
  status_word_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    (st_q == ST_STATUS) && !bad_cmd_q |=> cmd_q[15] && (cmd_q[13] != cmd_q[11])
    && (cmd_q[11] == $past(p1_fail_q || p2_fail_q)))
    else $error("status word does not match test outcome");
  next_addr_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    s_done |=> o_next_addr == $past(base_q) + $past(link_q))
    else $error("next block address wrong");
  p1_stop_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    s_p1_wrap |=> (st_q == ST_P1_CHK) && (bo_cnt_q == 10'h000)
    && (slot_cnt_q == 11'h400) && (col_cnt_q == 4'h0))
    else $error("phase one stop point misaligned");
  p1_length_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    (st_q == ST_P1_RST) |=> (st_q == ST_P1_RUN) [*8] ##1 (st_q == ST_P1_RUN))
    else $error("phase one ended early");
  p2_cfg_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    (st_q == ST_P2_RUN) && $past(st_q == ST_P2_RUN) |-> o_bof_cfg == 16'h0363)
    else $error("phase two setup not applied");
  cfg_restore_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    (st_q == ST_IDLE) && $past(st_q == ST_IDLE) |-> o_bof_cfg == $past(cfg_q))
    else $error("operating setup not restored");

  sequence s_lfsr_ones;
    (st_q == ST_P1_RUN) && all_ones10(lfsr_q[9:0]);
  endsequence

  sequence s_p2_hit;
    (st_q == ST_P2_RUN) && (bo_cnt_q >= wait_len);
  endsequence

  sequence s_rd_data;
    !o_hreadyout ##1 o_hreadyout;
  endsequence

  busy_start_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    go |=> o_busy && (o_unit_state == UNIT_ACTIVE) && (st_q == ST_DECODE))
    else $error("start request did not activate the unit");
  done_flags_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    s_done |=> !o_busy && (o_exec_irq == $past(cmd_q[29])))
    else $error("completion pulse or busy wrong");
  p1_reset_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    (st_q == ST_P1_RST) |=> (lfsr_q == 30'h0000_0000) && (bo_cnt_q == 10'h000)
    && (slot_cnt_q == 11'h000) && (col_cnt_q == 4'h0) && (bo_sr_q == 10'h000))
    else $error("phase one did not clear every stage");
  p1_step_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    (st_q == ST_P1_RUN) |=> (bo_cnt_q == $past(bo_cnt_q) + 10'h001)
    && (slot_cnt_q == $past(slot_cnt_q) + 11'h001) && (col_cnt_q == $past(col_cnt_q) + 4'h1))
    else $error("phase one stages did not step together");
  sr_ones_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    s_lfsr_ones |-> all_ones10(bo_sr_q))
    else $error("shift register not full when random low bits are ones");
  p1_pass_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    (st_q == ST_P1_CHK) |=> !p1_fail_q && (st_q == ST_P2_RST))
    else $error("phase one reported a fault");
  p2_reset_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    (st_q == ST_P2_RST) |=> (lfsr_q == 30'h0000_0000) && (bo_sr_q == 10'h000)
    && (col_cnt_q == 4'h0) && (o_bof_cfg == `BST_P2_CFG))
    else $error("phase two did not start from a clean setup");
  p2_collide_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    s_p2_hit |=> (bo_cnt_q == 10'h000) && (col_cnt_q == $past(col_cnt_q) + 4'h1))
    else $error("emulated collision not counted");
  p2_end_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    (st_q == ST_P2_CHK) |-> bo_sr_q[9] && (col_cnt_q == `BST_P2_COLS))
    else $error("phase two stopped at the wrong collision");
  p2_pass_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    (st_q == ST_P2_CHK) |=> !p2_fail_q && (st_q == ST_STATUS))
    else $error("phase two reported a fault");
  bad_cmd_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    (st_q == ST_STATUS) && bad_cmd_q |=> cmd_q[15] && !cmd_q[13] && !cmd_q[11])
    else $error("unknown command not reported as an error");
  rd_wait_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    i_hsel && i_htrans[1] && i_hready && !i_hwrite |=> s_rd_data)
    else $error("read data phase not one wait state");
  wr_nowait_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    i_hsel && i_htrans[1] && i_hready && i_hwrite |=> o_hreadyout && !o_hresp)
    else $error("write data phase stalled or errored");
endmodule
`default_nettype wire

// ===== tb/bst_top_tb.sv
// Self-checking testbench for the backoff self-test command engine
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin \
  n_compared++; \
  if ((gt) !== (ex)) begin \
    error_cnt++; \
    $display("Error %s expected %h seen %h", nm, ex, gt); \
  end \
end
module bst_top_tb;
  import bst_pkg::*;
  typedef struct packed {logic [31:0] a; logic [31:0] w; logic [31:0] e;} bst_reg_row_t;
  // Flags f: expected exec pulse, expected not-active pulse, unit state checked
  typedef struct packed {
    logic [31:0] cmd; logic [31:0] link; logic [31:0] base; logic [15:0] cfg;
    logic [1:0] ctrl; logic [31:0] stat; logic [2:0] f; bst_unit_t st;
  } bst_cmd_row_t;
  logic clk, rst_n, hsel, hwrite, hready, hresp, exec_irq, na_irq, busy, p2_seen;
  logic [31:0] haddr, hwdata, hrdata, next_addr, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [15:0] bof;
  bst_unit_t ust;
  int error_cnt, n_compared, n_exec, n_na;
  bst_reg_row_t rrow [8] = '{
    '{32'h0000_0000, 32'h2007_0000, 32'h2007_0000},
    '{32'h0000_0004, 32'hA5A5_5A5A, 32'hA5A5_5A5A},
    '{32'h0000_0008, 32'h0000_1000, 32'h0000_1000},
    '{32'h0000_0010, 32'hFFFF_1234, 32'h0000_1234},
    '{32'h0000_000C, 32'h0000_0002, 32'h0000_0002},
    '{32'h0000_0014, 32'hFFFF_FFFF, 32'h0000_0000},
    '{32'h0000_0018, 32'hFFFF_FFFF, 32'h0000_0000},
    '{32'h0000_001C, 32'hFFFF_FFFF, 32'h0000_0000}
  };
  // Row 1 wraps base plus link past the top of the 32-bit space
  // Reserved command bits 28:19 are written as zero in every row
  // Row 0 has neither last nor suspend set, so the unit must stay active
  bst_cmd_row_t crow [5] = '{
    '{32'h2007_0000, 32'h0000_0040, 32'h0001_0000, 16'h1234, 2'h1,
      32'h2007_A000, 3'b101, UNIT_ACTIVE},
    '{32'h8007_0000, 32'h0000_0020, 32'hFFFF_FFF0, 16'h0F0F, 2'h1,
      32'h8007_A000, 3'b011, UNIT_IDLE},
    '{32'h4007_0000, 32'h0000_0004, 32'h0000_0100, 16'h0000, 2'h1,
      32'h4007_A000, 3'b001, UNIT_SUSP},
    '{32'h4007_0000, 32'h0000_0008, 32'h0000_0200, 16'hFFFF, 2'h3,
      32'h4007_A000, 3'b011, UNIT_SUSP},
    '{32'hA005_0000, 32'h0000_000C, 32'h0000_0300, 16'h5A5A, 2'h1,
      32'hA005_8000, 3'b111, UNIT_IDLE}
  };

  bst_top dut (.i_sys_clk(clk), .i_reset_n(rst_n), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
    .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
    .o_exec_irq(exec_irq), .o_not_active_irq(na_irq), .o_busy(busy),
    .o_next_addr(next_addr), .o_bof_cfg(bof), .o_unit_state(ust));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Pulses are counted so that a double pulse shows up as a wrong count
  always @(posedge clk) begin
    if (exec_irq === 1'b1) n_exec++;
    if (na_irq === 1'b1) n_na++;
    if (busy === 1'b1 && bof === 16'h0363) p2_seen = 1'b1;
  end

  task automatic end_of_test();
    $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 100);
    if (hready !== 1'b1) begin
      error_cnt++;
      end_of_test();
    end
  endtask

  task automatic ahb_write(input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= 1'b1;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
  endtask

  task automatic ahb_read(input logic [31:0] a, output logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= 1'b0;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    wait_rdy();
    d = hrdata;
    `CHK("hresp", 1'b0, hresp)
  endtask

  task automatic chk_idle();
    `CHK("hreadyout", 1'b1, hready)
    `CHK("busy", 1'b0, busy)
    `CHK("exec_irq", 1'b0, exec_irq)
    `CHK("na_irq", 1'b0, na_irq)
    `CHK("next_addr", 32'h0000_0000, next_addr)
    `CHK("bof_cfg", 16'h0000, bof)
    `CHK("unit", UNIT_IDLE, ust)
  endtask

  task automatic run_cmd(input bst_cmd_row_t r);
    int n;
    ahb_write(32'h0000_0010, {16'h0000, r.cfg});
    ahb_write(32'h0000_0000, r.cmd);
    ahb_write(32'h0000_0004, r.link);
    ahb_write(32'h0000_0008, r.base);
    n_exec = 0;
    n_na = 0;
    p2_seen = 1'b0;
    ahb_write(32'h0000_000C, {30'h0, r.ctrl});
    ahb_read(32'h0000_0000, rd);
    `CHK("busy", 1'b1, busy)
    `CHK("cmd_c_running", 1'b0, rd[15])
    n = 0;
    while (busy === 1'b1 && n < 20000) begin
      @(posedge clk);
      n++;
    end
    if (busy !== 1'b0) begin
      error_cnt++;
      end_of_test();
    end
    repeat (3) @(posedge clk);
    ahb_read(32'h0000_0000, rd);
    `CHK("cmd_status", r.stat, rd)
    `CHK("exec_cnt", int'(r.f[2]), n_exec)
    `CHK("na_cnt", int'(r.f[1]), n_na)
    if (r.f[0]) `CHK("unit", r.st, ust)
    `CHK("next_addr", r.base + r.link, next_addr)
    ahb_read(32'h0000_0018, rd);
    `CHK("next_reg", r.base + r.link, rd)
    `CHK("bof_cfg", r.cfg, bof)
    `CHK("p2_cfg", r.cmd[18:16] == 3'h7, p2_seen)
  endtask

  initial begin
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0000_0000;
    error_cnt = 0;
    n_compared = 0;
    p2_seen = 1'b0;
    repeat (6) @(posedge clk);
    chk_idle();
    rst_n <= 1'b1;
    @(posedge clk);
    chk_idle();
    $display("Test reset done");
    for (int i = 0; i < 8; i++) begin
      ahb_write(rrow[i].a, rrow[i].w);
      ahb_read(rrow[i].a, rd);
      `CHK("reg_read", rrow[i].e, rd)
    end
    $display("Test registers done");
    for (int i = 0; i < 5; i++) begin
      run_cmd(crow[i]);
      $display("Test command %0d done", i);
    end
    // Reset in mid-run must abandon the test and leave the unit idle
    ahb_write(32'h0000_0000, 32'h2007_0000);
    ahb_write(32'h0000_000C, 32'h0000_0001);
    repeat (200) @(posedge clk);
    `CHK("busy_mid", 1'b1, busy)
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk_idle();
    rst_n <= 1'b1;
    @(posedge clk);
    chk_idle();
    ahb_read(32'h0000_0010, rd);
    `CHK("cfg_rst", 32'h0000_0000, rd)
    ahb_read(32'h0000_0000, rd);
    `CHK("cmd_rst", 32'h0000_0000, rd)
    run_cmd(crow[0]);
    $display("Test mid-run reset done");
    end_of_test();
  end
endmodule
`default_nettype wire
